// *** rtl/ppl_pkg.sv ***
// constants and types for the piezo position loop
`default_nettype none
package ppl_pkg;
    localparam int ADC_W = 18;
    localparam int DAT_W = 18;
    localparam int COEF_W = 16;
    localparam int FRAC_W = 12;
    localparam int LIN_SEG_W = 4;
    localparam int LIN_N = 16;
    // register byte offsets
    localparam logic [7:0] OFF_CTRL = 8'h00;
    localparam logic [7:0] OFF_SETPT = 8'h04;
    localparam logic [7:0] OFF_SWCMD = 8'h08;
    localparam logic [7:0] OFF_KP = 8'h0c;
    localparam logic [7:0] OFF_KI = 8'h10;
    localparam logic [7:0] OFF_KD = 8'h14;
    localparam logic [7:0] OFF_NOTCH = 8'h18;
    localparam logic [7:0] OFF_STATUS = 8'h1c;
    localparam logic [7:0] OFF_POS = 8'h20;
    localparam logic [7:0] OFF_DRIVE = 8'h24;
    localparam logic [7:0] OFF_RAW = 8'h28;
    localparam logic [7:0] OFF_LIN = 8'h40;
    // control field positions
    localparam int CTRL_CLOSED = 0;
    localparam int CTRL_N1_EN = 1;
    localparam int CTRL_N2_EN = 2;
    localparam int CTRL_DLP_EN = 3;
    localparam int CTRL_JOY_SEL = 4;
    localparam int CTRL_EXT_SEL = 5;
    localparam int CTRL_ERR_CLR = 8;
    // status field positions
    localparam int ST_MISMATCH = 0;
    localparam int ST_UNCAL = 1;
    localparam int ST_DISC_ERR = 2;
    localparam int ST_LOADED = 3;
    localparam int ST_CLOSED = 4;
    // position clip: full travel is 2**17, -4% of it is -5243
    localparam logic signed [DAT_W-1:0] POS_MAX = 18'sh20000 - 18'sh1;
    localparam logic signed [DAT_W-1:0] POS_MIN = -18'sd5243;
    localparam logic signed [DAT_W-1:0] DRV_MAX = 18'sh1ffff;
    localparam logic signed [DAT_W-1:0] DRV_MIN = -18'sh1ffff;
    localparam logic [7:0] NOTCH_RST = 8'h40;
    typedef enum logic [1:0] {PPL_BOOT_FETCH, PPL_BOOT_CHECK, PPL_RUN} ppl_boot_e;
endpackage
`default_nettype wire

// *** rtl/ppl_notch.sv ***
// one switchable second-order notch stage
`default_nettype none
module ppl_notch (
    // clock and reset
    input  wire logic                                CLK_SYS,
    input  wire logic                                RST_N,
    // control
    input  wire logic                                step,
    input  wire logic                                enable,
    input  wire logic [7:0]                          coef,
    // data
    input  wire logic signed [ppl_pkg::DAT_W-1:0]    din,
    output logic signed [ppl_pkg::DAT_W-1:0]         dout
);
    // y = x - 2c*x1 + x2 + 2c*y1 - (1-r)... simplified: notch with fixed pole radius
    logic signed [ppl_pkg::DAT_W-1:0] x1_r, x2_r, y1_r, y2_r;
    logic signed [ppl_pkg::DAT_W+9:0] acc;
    logic signed [ppl_pkg::DAT_W-1:0] y_nxt;
    logic signed [ppl_pkg::DAT_W+9:0] lim_hi, lim_lo;
    assign lim_hi = (ppl_pkg::DAT_W+10)'(ppl_pkg::DRV_MAX);
    assign lim_lo = (ppl_pkg::DAT_W+10)'(ppl_pkg::DRV_MIN);
    // zeros on the unit circle, poles at 7/8 radius; coef is cos(w) in q1.6
    assign acc = (ppl_pkg::DAT_W+10)'(din) + (ppl_pkg::DAT_W+10)'(x2_r)
               - (((ppl_pkg::DAT_W+10)'(x1_r) * $signed({2'b00, coef})) >>> 5)
               + ((((ppl_pkg::DAT_W+10)'(y1_r) * $signed({2'b00, coef})) >>> 5) * 5'sd7 >>> 3)
               - (((ppl_pkg::DAT_W+10)'(y2_r) * 8'sd49) >>> 6);
    assign y_nxt = acc > lim_hi ? ppl_pkg::DRV_MAX : acc < lim_lo ? ppl_pkg::DRV_MIN : acc[ppl_pkg::DAT_W-1:0];
    always_ff @(posedge CLK_SYS) begin
        if (!RST_N || !enable) begin
            x1_r <= '0;
            x2_r <= '0;
            y1_r <= '0;
            y2_r <= '0;
            dout <= '0;
        end else if (step) begin
            x2_r <= x1_r;
            x1_r <= din;
            y2_r <= y1_r;
            y1_r <= y_nxt;
            dout <= y_nxt;
        end
    end
endmodule
`default_nettype wire

// *** rtl/ppl_core.sv ***
// piezo position loop: sensor path, pid, notches, command sum, apb registers
`default_nettype none
module ppl_core (
    // clock and reset
    input  wire logic                              CLK_SYS,
    input  wire logic                              RST_N,
    // apb slave
    input  wire logic                              PSEL,
    input  wire logic                              PENABLE,
    input  wire logic                              PWRITE,
    input  wire logic [7:0]                        PADDR,
    input  wire logic [31:0]                       PWDATA,
    output logic [31:0]                            PRDATA,
    output logic                                   PREADY,
    output logic                                   PSLVERR,
    // converter
    input  wire logic                              ADC_VALID,
    input  wire logic [ppl_pkg::ADC_W-1:0]         ADC_DATA,
    // command sources
    input  wire logic signed [ppl_pkg::DAT_W-1:0]  EXTERNAL_ANALOG_COMMAND,
    input  wire logic signed [ppl_pkg::DAT_W-1:0]  JOYSTICK_COMMAND,
    // stage presence and identity
    input  wire logic                              STAGE_PRESENT,
    input  wire logic [15:0]                       STAGE_ID,
    // non-volatile defaults
    input  wire logic [15:0]                       NV_STAGE_ID,
    input  wire logic [ppl_pkg::COEF_W-1:0]        NV_KP,
    input  wire logic [ppl_pkg::COEF_W-1:0]        NV_KI,
    input  wire logic [ppl_pkg::COEF_W-1:0]        NV_KD,
    // outputs
    output logic signed [ppl_pkg::DAT_W-1:0]       DRIVE_OUT,
    output logic                                   ERROR_LED,
    output logic                                   CLOSED_LOOP_LED
);
    localparam int DW = ppl_pkg::DAT_W;
    localparam int AW = DW + 20;
    // pin synchronisers
    logic adc_v_s1_r, adc_v_s2_r, adc_v_s3_r, pres_s1_r, pres_s2_r;
    logic [15:0] id_s1_r, id_s2_r;
    logic [ppl_pkg::ADC_W-1:0] adc_d_s1_r, adc_d_s2_r;
    logic signed [DW-1:0] ext_s1_r, ext_s2_r, joy_s1_r, joy_s2_r;
    always_ff @(posedge CLK_SYS) begin
        adc_v_s1_r <= RST_N & ADC_VALID;
        adc_v_s2_r <= RST_N & adc_v_s1_r;
        adc_v_s3_r <= RST_N & adc_v_s2_r;
        adc_d_s1_r <= ADC_DATA;
        adc_d_s2_r <= adc_d_s1_r;
        ext_s1_r <= EXTERNAL_ANALOG_COMMAND;
        ext_s2_r <= ext_s1_r;
        joy_s1_r <= JOYSTICK_COMMAND;
        joy_s2_r <= joy_s1_r;
        pres_s1_r <= STAGE_PRESENT;
        pres_s2_r <= pres_s1_r;
        id_s1_r <= STAGE_ID;
        id_s2_r <= id_s1_r;
    end
    // one step per converter sample
    wire step = adc_v_s2_r & ~adc_v_s3_r;

    // registers
    logic [7:0] ctrl_r;
    logic signed [DW-1:0] setpt_r, swcmd_r;
    logic [ppl_pkg::COEF_W-1:0] kp_r, ki_r, kd_r;
    logic [7:0] n1_coef_r, n2_coef_r;
    logic [DW-1:0] lin_r [ppl_pkg::LIN_N];
    logic mismatch_r, disc_err_r, loaded_r;
    ppl_pkg::ppl_boot_e boot_r;

    wire wr = PSEL & PENABLE & PWRITE;
    wire sel_lin = PADDR[7:6] == ppl_pkg::OFF_LIN[7:6] && PADDR[1:0] == 2'b00;
    wire [3:0] lin_idx = PADDR[5:2];
    wire closed = ctrl_r[ppl_pkg::CTRL_CLOSED];
    wire going_closed = wr && PADDR == ppl_pkg::OFF_CTRL && PWDATA[ppl_pkg::CTRL_CLOSED] && !closed;

    // linearisation: piecewise line through 16 breakpoints
    wire [ppl_pkg::LIN_SEG_W-1:0] seg = adc_d_s2_r[ppl_pkg::ADC_W-1 -: ppl_pkg::LIN_SEG_W];
    wire [ppl_pkg::ADC_W-5:0] frac = adc_d_s2_r[ppl_pkg::ADC_W-5:0];
    wire [DW-1:0] lin_a = lin_r[seg];
    // last segment extrapolated at full width so it cannot wrap
    wire signed [AW-1:0] lin_as = AW'($signed(lin_a));
    wire signed [AW-1:0] lin_b = (seg == 4'hf) ? lin_as + lin_as - AW'($signed(lin_r[4'he]))
                                               : AW'($signed(lin_r[seg + 4'h1]));
    wire signed [AW-1:0] lin_d = lin_b - lin_as;
    wire signed [AW-1:0] lin_p = lin_as + ((lin_d * $signed({1'b0, frac})) >>> (ppl_pkg::ADC_W - 4));
    // clip to -4% .. +100%
    wire signed [AW-1:0] pmax = AW'(ppl_pkg::POS_MAX);
    wire signed [AW-1:0] pmin = AW'(ppl_pkg::POS_MIN);
    wire signed [DW-1:0] pos_clip = lin_p > pmax ? ppl_pkg::POS_MAX : lin_p < pmin ? ppl_pkg::POS_MIN : lin_p[DW-1:0];
    logic signed [DW-1:0] pos_r;
    logic [ppl_pkg::ADC_W-1:0] raw_r;
    always_ff @(posedge CLK_SYS) begin
        if (!RST_N) begin
            pos_r <= '0;
            raw_r <= '0;
        end else if (step) begin
            pos_r <= pos_clip;
            raw_r <= adc_d_s2_r;
        end
    end

    // command sum
    wire signed [DW+1:0] cmd_sum = (DW+2)'(swcmd_r)
        + (ctrl_r[ppl_pkg::CTRL_EXT_SEL] ? (DW+2)'(ext_s2_r) : '0)
        + (ctrl_r[ppl_pkg::CTRL_JOY_SEL] ? (DW+2)'(joy_s2_r) : '0);

    // pid
    logic signed [AW-1:0] integ_r;
    logic signed [DW-1:0] err_prev_r, dfilt_r;
    wire signed [DW:0] err = (DW+1)'($signed(setpt_r + cmd_sum[DW-1:0])) - (DW+1)'(pos_r);
    wire signed [DW:0] draw = err - (DW+1)'(err_prev_r);
    wire signed [DW:0] dterm = ctrl_r[ppl_pkg::CTRL_DLP_EN]
        ? (DW+1)'(dfilt_r) + ((draw - (DW+1)'(dfilt_r)) >>> 2) : draw;
    wire signed [AW-1:0] integ_nxt = integ_r + AW'(err);
    wire signed [AW-1:0] pid_sum = ((AW'(err) * $signed({1'b0, kp_r}))
        + ((integ_r >>> 6) * $signed({1'b0, ki_r}))
        + (AW'(dterm) * $signed({1'b0, kd_r}))) >>> ppl_pkg::FRAC_W;
    wire signed [AW-1:0] dmx = AW'(ppl_pkg::DRV_MAX);
    wire signed [AW-1:0] dmn = AW'(ppl_pkg::DRV_MIN);
    wire signed [DW-1:0] pid_out = pid_sum > dmx ? ppl_pkg::DRV_MAX : pid_sum < dmn ? ppl_pkg::DRV_MIN : pid_sum[DW-1:0];
    logic signed [DW-1:0] pid_r;
    always_ff @(posedge CLK_SYS) begin
        if (!RST_N || !closed) begin
            integ_r <= '0;
            err_prev_r <= '0;
            dfilt_r <= '0;
            pid_r <= '0;
        end else if (step) begin
            integ_r <= (integ_nxt > (dmx <<< 6) || integ_nxt < (dmn <<< 6)) ? integ_r : integ_nxt;
            err_prev_r <= err[DW-1:0];
            dfilt_r <= dterm[DW-1:0];
            pid_r <= pid_out;
        end
    end

    // notch cascade: notch 1 one tick behind the pid stage, notch 2 one tick behind notch 1
    logic step_d_r, step_dd_r;
    always_ff @(posedge CLK_SYS) begin
        step_d_r <= RST_N & step;
        step_dd_r <= RST_N & step_d_r;
    end
    logic signed [DW-1:0] n1_out, n2_out, n1_in, n2_in, n2_src;
    assign n1_in = pid_r;
    assign n2_src = ctrl_r[ppl_pkg::CTRL_N1_EN] ? n1_out : pid_r;
    assign n2_in = n2_src;
    ppl_notch u_notch1 (
        .CLK_SYS (CLK_SYS),
        .RST_N   (RST_N),
        .step    (step_d_r),
        .enable  (ctrl_r[ppl_pkg::CTRL_N1_EN] & closed),
        .coef    (n1_coef_r),
        .din     (n1_in),
        .dout    (n1_out)
    );
    ppl_notch u_notch2 (
        .CLK_SYS (CLK_SYS),
        .RST_N   (RST_N),
        .step    (step_dd_r),
        .enable  (ctrl_r[ppl_pkg::CTRL_N2_EN] & closed),
        .coef    (n2_coef_r),
        .din     (n2_in),
        .dout    (n2_out)
    );
    wire signed [DW-1:0] loop_out = ctrl_r[ppl_pkg::CTRL_N2_EN] ? n2_out : n2_src;
    // open-loop drive is the command itself, saturated
    wire signed [DW+1:0] cmx = (DW+2)'(ppl_pkg::DRV_MAX);
    wire signed [DW+1:0] cmn = (DW+2)'(ppl_pkg::DRV_MIN);
    wire signed [DW-1:0] open_out = cmd_sum > cmx ? ppl_pkg::DRV_MAX : cmd_sum < cmn ? ppl_pkg::DRV_MIN : cmd_sum[DW-1:0];
    always_ff @(posedge CLK_SYS) begin
        if (!RST_N) begin
            DRIVE_OUT <= '0;
        end else begin
            DRIVE_OUT <= closed ? loop_out : open_out;
        end
    end

    // power-up: load defaults, check identity
    wire id_ok = id_s2_r == NV_STAGE_ID;
    always_ff @(posedge CLK_SYS) begin
        if (!RST_N) begin
            boot_r <= ppl_pkg::PPL_BOOT_FETCH;
            mismatch_r <= 1'b0;
            loaded_r <= 1'b0;
        end else begin
            case (boot_r)
                ppl_pkg::PPL_BOOT_FETCH: begin
                    loaded_r <= 1'b1;
                    boot_r <= ppl_pkg::PPL_BOOT_CHECK;
                end
                ppl_pkg::PPL_BOOT_CHECK: begin
                    mismatch_r <= ~id_ok;
                    boot_r <= ppl_pkg::PPL_RUN;
                end
                ppl_pkg::PPL_RUN: boot_r <= ppl_pkg::PPL_RUN;
                default: boot_r <= ppl_pkg::PPL_BOOT_FETCH;
            endcase
        end
    end
    wire boot_load = boot_r == ppl_pkg::PPL_BOOT_FETCH;

    // register writes
    wire disc_set = closed & ~pres_s2_r;
    wire disc_clr = wr && PADDR == ppl_pkg::OFF_CTRL && PWDATA[ppl_pkg::CTRL_ERR_CLR];
    always_ff @(posedge CLK_SYS) begin
        if (!RST_N) begin
            ctrl_r <= '0;
            setpt_r <= '0;
            swcmd_r <= '0;
            kp_r <= '0;
            ki_r <= '0;
            kd_r <= '0;
            n1_coef_r <= ppl_pkg::NOTCH_RST;
            n2_coef_r <= ppl_pkg::NOTCH_RST;
            disc_err_r <= 1'b0;
        end else begin
            disc_err_r <= disc_set | (disc_err_r & ~disc_clr);
            if (boot_load) begin
                kp_r <= NV_KP;
                ki_r <= NV_KI;
                kd_r <= NV_KD;
            end else if (wr) begin
                case (PADDR)
                    ppl_pkg::OFF_CTRL: ctrl_r <= PWDATA[7:0];
                    ppl_pkg::OFF_SETPT: setpt_r <= PWDATA[DW-1:0];
                    ppl_pkg::OFF_SWCMD: swcmd_r <= PWDATA[DW-1:0];
                    ppl_pkg::OFF_KP: kp_r <= PWDATA[ppl_pkg::COEF_W-1:0];
                    ppl_pkg::OFF_KI: ki_r <= PWDATA[ppl_pkg::COEF_W-1:0];
                    ppl_pkg::OFF_KD: kd_r <= PWDATA[ppl_pkg::COEF_W-1:0];
                    ppl_pkg::OFF_NOTCH: begin
                        n1_coef_r <= PWDATA[7:0];
                        n2_coef_r <= PWDATA[15:8];
                    end
                    default: ;
                endcase
            end
            // bumpless entry: setpoint absorbs position minus command
            if (going_closed) begin
                setpt_r <= pos_r - cmd_sum[DW-1:0];
            end
        end
    end
    genvar gi;
    generate
        for (gi = 0; gi < ppl_pkg::LIN_N; gi++) begin : g_lin
            always_ff @(posedge CLK_SYS) begin
                if (!RST_N) begin
                    lin_r[gi] <= DW'(gi) << (DW - 5); // identity curve over half range
                end else if (wr && sel_lin && lin_idx == gi) begin
                    lin_r[gi] <= PWDATA[DW-1:0];
                end
            end
        end
    endgenerate

    // read mux
    wire [31:0] status = {27'h0, closed, loaded_r, disc_err_r, mismatch_r, mismatch_r};
    logic [31:0] rd;
    always_comb begin
        case (PADDR)
            ppl_pkg::OFF_CTRL: rd = {24'h0, ctrl_r};
            ppl_pkg::OFF_SETPT: rd = 32'(setpt_r);
            ppl_pkg::OFF_SWCMD: rd = 32'(swcmd_r);
            ppl_pkg::OFF_KP: rd = {16'h0, kp_r};
            ppl_pkg::OFF_KI: rd = {16'h0, ki_r};
            ppl_pkg::OFF_KD: rd = {16'h0, kd_r};
            ppl_pkg::OFF_NOTCH: rd = {16'h0, n2_coef_r, n1_coef_r};
            ppl_pkg::OFF_STATUS: rd = status;
            ppl_pkg::OFF_POS: rd = 32'(pos_r);
            ppl_pkg::OFF_DRIVE: rd = 32'(DRIVE_OUT);
            ppl_pkg::OFF_RAW: rd = {14'h0, raw_r};
            default: rd = sel_lin ? {14'h0, lin_r[lin_idx]} : 32'h0;
        endcase
    end
    wire mapped = sel_lin || PADDR <= ppl_pkg::OFF_RAW;
    always_ff @(posedge CLK_SYS) begin
        if (!RST_N) begin
            PRDATA <= '0;
        end else if (PSEL && !PENABLE && !PWRITE) begin
            PRDATA <= rd;
        end
    end
    assign PREADY = 1'b1;
    assign PSLVERR = PSEL & PENABLE & (~mapped | (PADDR[1:0] != 2'b00));
    assign ERROR_LED = mismatch_r | disc_err_r;
    assign CLOSED_LOOP_LED = closed;
endmodule
`default_nettype wire

// *** tb/ppl_stage_model.sv ***
// stage model: sensor converter samples and stage presence
`default_nettype none
module ppl_stage_model #(
    parameter int PERIOD = 16
) (
    // clock and reset
    input  wire logic        clk_sys,
    input  wire logic        rst_n,
    // stage state set by the bench
    input  wire logic [17:0] raw,
    input  wire logic        present,
    // sensor side
    output logic             adc_valid,
    output logic [17:0]      adc_data,
    output logic             stage_present
);
    timeunit 1ns;
    timeprecision 1ps;
    int cnt = 0;
    initial begin
        adc_valid = 1'b0;
        adc_data = 18'h0;
        stage_present = 1'b1;
    end
    // data held five clocks from the rising strobe, then scrambled
    always @(posedge clk_sys) begin
        cnt <= (!rst_n || cnt == PERIOD - 1) ? 0 : cnt + 1;
        adc_valid <= rst_n && cnt < 4;
        adc_data <= (cnt < 5) ? raw : ~raw;
        stage_present <= present;
    end
endmodule
`default_nettype wire

// *** tb/ppl_core_assertions.sv ***
// concurrent checks on the position loop ports
`default_nettype none
module ppl_core_assertions (
    // clock and reset
    input wire logic              CLK_SYS,
    input wire logic              RST_N,
    // apb
    input wire logic              PSEL,
    input wire logic              PENABLE,
    input wire logic              PWRITE,
    input wire logic [7:0]        PADDR,
    input wire logic [31:0]       PWDATA,
    input wire logic [31:0]       PRDATA,
    input wire logic              PREADY,
    input wire logic              PSLVERR,
    // stage and outputs
    input wire logic              ADC_VALID,
    input wire logic              STAGE_PRESENT,
    input wire logic signed [17:0] DRIVE_OUT,
    input wire logic              ERROR_LED,
    input wire logic              CLOSED_LOOP_LED
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking @(posedge CLK_SYS); endclocking
    default disable iff (!RST_N);
    logic       adc_q;
    logic       led_q;
    logic [3:0] quiet_r;
    wire        mapped = PADDR[1:0] == 2'b00 && (PADDR <= 8'h28 || (PADDR >= 8'h40 && PADDR <= 8'h7c));
    wire        access = PSEL && PENABLE;
    wire        restart = !RST_N || !CLOSED_LOOP_LED || PSEL || (ADC_VALID && !adc_q) || CLOSED_LOOP_LED != led_q;
    // cycles since the last event that may move the closed-loop drive
    always_ff @(posedge CLK_SYS) begin
        adc_q <= ADC_VALID;
        led_q <= CLOSED_LOOP_LED;
        quiet_r <= restart ? 4'h0 : (quiet_r == 4'hf ? quiet_r : quiet_r + 4'h1);
    end
    sequence s_wr_ctrl;
        access && PWRITE && PADDR == ppl_pkg::OFF_CTRL;
    endsequence
    sequence s_closed_absent;
        (CLOSED_LOOP_LED && !STAGE_PRESENT) [*4];
    endsequence
    property p_rst_vals;
        $rose(RST_N) |-> DRIVE_OUT == 18'sh0 && !CLOSED_LOOP_LED && !ERROR_LED && PRDATA == 32'h0;
    endproperty
    property p_ready;
        PSEL |-> PREADY;
    endproperty
    property p_err_bad;
        access && !mapped |-> PSLVERR;
    endproperty
    property p_err_ok;
        access && mapped |-> !PSLVERR;
    endproperty
    property p_mode;
        s_wr_ctrl |=> CLOSED_LOOP_LED == $past(PWDATA[0]);
    endproperty
    property p_disc;
        s_closed_absent |=> ERROR_LED;
    endproperty
    property p_sat;
        DRIVE_OUT <= ppl_pkg::DRV_MAX && DRIVE_OUT >= ppl_pkg::DRV_MIN;
    endproperty
    property p_quiet;
        quiet_r >= 4'ha |-> $stable(DRIVE_OUT);
    endproperty
    a_rst_vals: assert property (p_rst_vals) else $error("outputs not idle after reset");
    a_ready: assert property (p_ready) else $error("pready low");
    a_err_bad: assert property (p_err_bad) else $error("unmapped access not refused");
    a_err_ok: assert property (p_err_ok) else $error("mapped access refused");
    a_mode: assert property (p_mode) else $error("mode led not following control write");
    a_disc: assert property (p_disc) else $error("no error with stage absent in closed loop");
    a_sat: assert property (p_sat) else $error("drive outside saturation range");
    a_quiet: assert property (p_quiet) else $error("drive moved between samples");
endmodule
`default_nettype wire

// *** tb/ppl_tb.sv ***
// self-checking bench for the piezo position loop
`default_nettype none
`define CHK(g, e) begin checks_done++; if ((g) !== (e)) begin n_fail++; \
    $display("MISMATCH t=%0t got %0h exp %0h", $time, (g), (e)); end end
module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    logic               clk_sys = 1'b0;
    logic               rst_n = 1'b0;
    logic               psel = 1'b0;
    logic               penable = 1'b0;
    logic               pwrite = 1'b0;
    logic               present = 1'b1;
    logic [7:0]         paddr = 8'h00;
    logic [31:0]        pwdata = 32'h0;
    logic [31:0]        seed = 32'd9235;
    logic [31:0]        prdata, rd, cw;
    logic               pready, pslverr, adc_valid, stage_ok, err_led, cl_led, e;
    logic [17:0]        adc_data;
    logic [17:0]        raw = 18'h0;
    logic signed [17:0] ext = 18'sh0;
    logic signed [17:0] joy = 18'sh0;
    logic signed [17:0] drive, d0;
    logic [15:0]        kp, ki, kd;
    logic [15:0]        id = 16'h5a5a;    // arbitrary stage identity
    logic [15:0]        nv_id = 16'h5a5a; // arbitrary stored identity
    int                 n_fail = 0;
    int                 checks_done = 0;
    int                 sw;
    int                 q[$];
    int                 lv[4] = '{1000, -100000, 131071, 1000};
    always #12.5 clk_sys = ~clk_sys;
    ppl_core u_ppl_core (
        .CLK_SYS(clk_sys), .RST_N(rst_n), .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite),
        .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr),
        .ADC_VALID(adc_valid), .ADC_DATA(adc_data), .EXTERNAL_ANALOG_COMMAND(ext),
        .JOYSTICK_COMMAND(joy), .STAGE_PRESENT(stage_ok), .STAGE_ID(id), .NV_STAGE_ID(nv_id),
        .NV_KP(kp), .NV_KI(ki), .NV_KD(kd), .DRIVE_OUT(drive), .ERROR_LED(err_led),
        .CLOSED_LOOP_LED(cl_led));
    ppl_stage_model u_ppl_stage_model (
        .clk_sys(clk_sys), .rst_n(rst_n), .raw(raw), .present(present),
        .adc_valid(adc_valid), .adc_data(adc_data), .stage_present(stage_ok));
    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction
    function automatic int sat(int v, int lo, int hi);
        return v > hi ? hi : (v < lo ? lo : v);
    endfunction
    task automatic summarize();
        $display("checks %0d mismatches %0d", checks_done, n_fail);
        if (n_fail == 0 && checks_done > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge clk_sys);
    endtask
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int i;
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk_sys);
        penable <= 1'b1;
        for (i = 0; i < 50; i++) begin
            @(posedge clk_sys);
            if (pready === 1'b1) break;
        end
        if (i == 50) begin
            n_fail++;
            summarize();
        end
        rd = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge clk_sys);
    endtask
    task automatic do_reset();
        rst_n <= 1'b0;
        cyc(20);
        rst_n <= 1'b1;
        cyc(3);
    endtask
    initial begin
        rd = rnd();
        kp = {5'h01, rd[10:0]};
        ki = {8'h00, rd[23:16]};
        kd = {8'h00, rd[31:24]};
        q = '{int'(kp), int'(ki), int'(kd)};
        do_reset();
        `CHK(drive, 18'sh0)
        `CHK(cl_led, 1'b0)
        foreach (q[i]) begin
            apb(1'b0, ppl_pkg::OFF_KP + 8'(4 * i), 32'h0);
            `CHK(rd, 32'(q[i]))
        end
        apb(1'b0, ppl_pkg::OFF_NOTCH, 32'h0);
        `CHK(rd, {16'h0, ppl_pkg::NOTCH_RST, ppl_pkg::NOTCH_RST})
        apb(1'b0, ppl_pkg::OFF_STATUS, 32'h0);
        `CHK(rd[4:0], 5'b01000)
        for (int a = 8'h30; a < 8'h54; a += 8'h12) begin
            apb(1'b0, 8'(a), 32'h0);
            `CHK({e, rd}, 33'h1_0000_0000)
        end
        rd = rnd();
        raw <= rd[17:0];
        cyc(40);
        apb(1'b0, ppl_pkg::OFF_RAW, 32'h0);
        `CHK(rd, {14'h0, raw})
        raw <= 18'h0;
        foreach (lv[j]) begin
            for (int b = 0; b < 16; b++) apb(1'b1, ppl_pkg::OFF_LIN + 8'(4 * b), 32'(lv[j]));
            cyc(40);
            apb(1'b0, ppl_pkg::OFF_POS, 32'h0);
            `CHK(rd, 32'(sat(lv[j], ppl_pkg::POS_MIN, ppl_pkg::POS_MAX)))
        end
        // last segment extrapolates past full travel
        apb(1'b1, ppl_pkg::OFF_LIN + 8'h38, 32'h0);
        apb(1'b1, ppl_pkg::OFF_LIN + 8'h3c, 32'(ppl_pkg::POS_MAX));
        raw <= 18'h3ffff;
        cyc(40);
        apb(1'b0, ppl_pkg::OFF_POS, 32'h0);
        `CHK(rd, 32'(ppl_pkg::POS_MAX))
        raw <= 18'h0;
        for (int m = 0; m < 4; m++) begin
            rd = rnd();
            sw = int'(rd[16:0]) - 65536;
            ext <= 18'(int'(rd[31:15]) - 65536);
            rd = rnd();
            joy <= 18'(int'(rd[16:0]) - 65536);
            cw = {26'h0, m[1:0], rd[19:17], 1'b0};
            apb(1'b1, ppl_pkg::OFF_SWCMD, 32'(sw));
            apb(1'b1, ppl_pkg::OFF_CTRL, cw);
            cyc(8);
            sw += m[1] ? int'(ext) : 0;
            sw += m[0] ? int'(joy) : 0;
            `CHK(drive, 18'(sat(sw, ppl_pkg::DRV_MIN, ppl_pkg::DRV_MAX)))
            apb(1'b0, ppl_pkg::OFF_CTRL, 32'h0);
            `CHK(rd, cw)
        end
        ext <= 18'sh0;
        joy <= 18'sh0;
        apb(1'b1, ppl_pkg::OFF_CTRL, 32'h08);
        apb(1'b1, ppl_pkg::OFF_SWCMD, 32'd300);
        cyc(8);
        apb(1'b1, ppl_pkg::OFF_CTRL, 32'h09);
        cyc(2);
        `CHK(cl_led, 1'b1)
        apb(1'b0, ppl_pkg::OFF_SETPT, 32'h0);
        `CHK(rd, 32'd700)
        apb(1'b1, ppl_pkg::OFF_KP, 32'h1000);
        apb(1'b0, ppl_pkg::OFF_KP, 32'h0);
        `CHK(rd, 32'h1000)
        d0 = drive;
        apb(1'b1, ppl_pkg::OFF_SETPT, 32'd3000);
        cyc(320);
        `CHK(drive > d0, 1'b1)
        // notch 1 at its reset frequency (dc) takes the steady drive away
        apb(1'b1, ppl_pkg::OFF_CTRL, 32'h0b);
        cyc(1000);
        `CHK(drive < 18'sd1000 && drive > -18'sd1000, 1'b1)
        present <= 1'b0;
        cyc(10);
        `CHK(err_led, 1'b1)
        present <= 1'b1;
        cyc(4);
        apb(1'b1, ppl_pkg::OFF_CTRL, 32'h100);
        apb(1'b0, ppl_pkg::OFF_STATUS, 32'h0);
        `CHK(rd[4:0], 5'b01000)
        cyc(8);
        `CHK(drive, 18'sd300)
        nv_id <= 16'h1234;
        do_reset();
        apb(1'b0, ppl_pkg::OFF_STATUS, 32'h0);
        `CHK(rd[3:0], 4'b1011)
        `CHK(err_led, 1'b1)
        apb(1'b1, ppl_pkg::OFF_SWCMD, -32'sd500);
        cyc(8);
        `CHK(drive, -18'sd500)
        apb(1'b0, ppl_pkg::OFF_DRIVE, 32'h0);
        `CHK(rd, -32'sd500)
        summarize();
    end
    initial begin
        cyc(100000);
        n_fail++;
        summarize();
    end
endmodule
bind ppl_core ppl_core_assertions u_ppl_core_assertions (.CLK_SYS, .RST_N, .PSEL, .PENABLE, .PWRITE,
    .PADDR, .PWDATA, .PRDATA, .PREADY, .PSLVERR, .ADC_VALID, .STAGE_PRESENT, .DRIVE_OUT, .ERROR_LED,
    .CLOSED_LOOP_LED);
`default_nettype wire
